// [logic/sar_conv_ctrl.v]
// conversion control of a 12-bit successive-approximation converter
`include "sar_consts.vh"
module sar_conv_ctrl (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // control from software and power management
  input wire start_strobe,
  input wire single_conversion_select,
  input wire [4:0] conv_div,
  input wire power_on,
  input wire status_clear,
  // frame start from a clock or a programmable_logic_block output
  input wire frame_start,
  // analog front end
  input wire comp_in,
  output wire [`SAR_RES_MSB:0] dac_code,
  output wire sample_hold,
  // result stream to cpu or dma
  output wire result_valid,
  input wire result_ready,
  output wire [`SAR_RES_MSB:0] result_data,
  // status
  output wire conv_done,
  output wire done_status,
  output wire conv_ready,
  output wire conv_busy,
  output wire trigger_missed
);
  // ----------------------------------------------------------------------
  // states and helpers
  // ----------------------------------------------------------------------
  localparam ST_OFF = 2'h0;
  localparam ST_IDLE = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam ST_PUSH = 2'h3;

  // one-hot mask of a result bit
  function [`SAR_RES_MSB:0] sar_mask;
    input [3:0] idx;
    begin
      sar_mask = {{(`SAR_RES_BITS - 1){1'b0}}, 1'b1} << idx;
    end
  endfunction

  // keep the divider inside the legal conversion-clock range
  function [4:0] sar_clamp_div;
    input [4:0] div;
    begin
      if (div < `SAR_DIV_MIN) begin
        sar_clamp_div = `SAR_DIV_MIN;
      end else if (div > `SAR_DIV_MAX) begin
        sar_clamp_div = `SAR_DIV_MAX;
      end else begin
        sar_clamp_div = div;
      end
    end
  endfunction

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [4:0] step_r;
  reg [4:0] step_nxt;
  reg [`SAR_RES_MSB:0] dac_r;
  reg [`SAR_RES_MSB:0] dac_nxt;
  reg [`SAR_RES_MSB:0] result_r;
  reg [`SAR_RES_MSB:0] result_nxt;
  reg [4:0] div_cnt_r;
  reg tick_r;
  reg [7:0] pup_cnt_r;
  reg ready_r;
  reg fs_s1_r;
  reg fs_s2_r;
  reg fs_s3_r;
  reg fs_level_r;
  reg pend_r;
  reg cont_run_r;
  reg status_r;
  reg missed_r;
  wire [4:0] div_eff;
  wire fs_rise;
  wire trigger;
  wire accept;
  wire buf_in_valid;
  wire buf_in_ready;
  wire read_done;
  wire [3:0] bit_idx;

  // ----------------------------------------------------------------------
  // conversion clock: a tick every div_eff reference cycles
  // ----------------------------------------------------------------------
  assign div_eff = sar_clamp_div(conv_div);

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_r <= 5'h00;
      tick_r <= 1'b0;
    end else begin
      if (div_cnt_r >= div_eff - 5'h01) begin
        div_cnt_r <= 5'h00;
        tick_r <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + 5'h01;
        tick_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // power-up wait
  // ----------------------------------------------------------------------
  // sleep drops power_on, so the wait reruns on every wake
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pup_cnt_r <= 8'h00;
      ready_r <= 1'b0;
    end else if (!power_on) begin
      pup_cnt_r <= 8'h00;
      ready_r <= 1'b0;
    end else if (!ready_r) begin
      if (pup_cnt_r == `SAR_PUP_CYCLES - 8'h01) begin
        ready_r <= 1'b1;
      end else begin
        pup_cnt_r <= pup_cnt_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // frame-start synchroniser and edge detect
  // ----------------------------------------------------------------------
  // the level only moves once the second and third stages agree
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fs_s1_r <= 1'b0;
      fs_s2_r <= 1'b0;
      fs_s3_r <= 1'b0;
      fs_level_r <= 1'b0;
    end else begin
      fs_s1_r <= frame_start;
      fs_s2_r <= fs_s1_r;
      fs_s3_r <= fs_s2_r;
      if (fs_s2_r == fs_s3_r) begin
        fs_level_r <= fs_s3_r;
      end
    end
  end

  assign fs_rise = fs_s2_r & fs_s3_r & ~fs_level_r;
  // an idle unconnected frame_start input stays low and never triggers
  assign trigger = start_strobe | fs_rise;
  // a trigger is taken only when ready and not already converting
  assign accept = trigger & ready_r & (state_r == ST_IDLE) & ~pend_r & ~cont_run_r;

  // ----------------------------------------------------------------------
  // trigger bookkeeping and continuous run
  // ----------------------------------------------------------------------
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_r <= 1'b0;
      cont_run_r <= 1'b0;
      missed_r <= 1'b0;
    end else begin
      if (state_r == ST_OFF) begin
        pend_r <= 1'b0;
      end else if (accept) begin
        pend_r <= 1'b1;
      end else if (state_r == ST_RUN) begin
        pend_r <= 1'b0;
      end
      if (!ready_r || single_conversion_select) begin
        cont_run_r <= 1'b0;
      end else if (accept) begin
        cont_run_r <= 1'b1;
      end
      // set wins over clear
      if (trigger && !accept) begin
        missed_r <= 1'b1;
      end else if (status_clear) begin
        missed_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  assign bit_idx = 4'hf - step_r[3:0];

  always @* begin
    state_nxt = state_r;
    step_nxt = step_r;
    dac_nxt = dac_r;
    result_nxt = result_r;
    case (state_r)
      ST_OFF: begin
        step_nxt = `SAR_RST_STEP;
        dac_nxt = `SAR_RST_CODE;
        if (ready_r) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (tick_r && (pend_r || cont_run_r)) begin
          state_nxt = ST_RUN;
          step_nxt = `SAR_RST_STEP;
          dac_nxt = `SAR_RST_CODE;
        end
      end
      ST_RUN: begin
        if (tick_r) begin
          step_nxt = step_r + 5'h01;
          if (step_r == `SAR_SAMPLE_LAST) begin
            dac_nxt = sar_mask(4'hb);
          end else if (step_r >= `SAR_BIT_FIRST && step_r <= `SAR_BIT_LAST) begin
            // keep the trial bit only when the input is at or above the dac
            dac_nxt = comp_in ? dac_r : (dac_r & ~sar_mask(bit_idx));
            if (bit_idx != 4'h0) begin
              dac_nxt = dac_nxt | sar_mask(bit_idx - 4'h1);
            end
          end else if (step_r == `SAR_STEP_LATCH) begin
            // the push cycle and the idle wait fill the eighteenth tick, so back to back
            // samples take eighteen ticks each
            result_nxt = dac_r;
            state_nxt = ST_PUSH;
            step_nxt = `SAR_RST_STEP;
          end
        end
      end
      ST_PUSH: begin
        // a full buffer holds the sequencer here, so no result is lost
        if (buf_in_ready) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    if (!power_on) begin
      state_nxt = ST_OFF;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_OFF;
      step_r <= `SAR_RST_STEP;
      dac_r <= `SAR_RST_CODE;
      result_r <= `SAR_RST_CODE;
    end else begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      dac_r <= dac_nxt;
      result_r <= result_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // result buffer
  // ----------------------------------------------------------------------
  assign buf_in_valid = (state_r == ST_PUSH);

  sar_buf2 u_buf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(result_r),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );

  assign read_done = result_valid & result_ready;

  // ----------------------------------------------------------------------
  // done status
  // ----------------------------------------------------------------------
  // sticky until a read or a clear; a completion in the same cycle wins
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= 1'b0;
    end else if (buf_in_valid && buf_in_ready) begin
      status_r <= 1'b1;
    end else if (read_done || status_clear) begin
      status_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign dac_code = dac_r;
  assign sample_hold = (state_r == ST_RUN) && (step_r <= `SAR_SAMPLE_LAST);
  // done follows the buffer, high while any unread result waits
  assign conv_done = result_valid;
  assign done_status = status_r;
  assign conv_ready = ready_r;
  assign conv_busy = (state_r == ST_RUN) || (state_r == ST_PUSH) || pend_r;
  assign trigger_missed = missed_r;
endmodule

// [logic/sar_consts.vh]
// constants shared by the conversion control and its result buffer
`ifndef SAR_CONSTS_VH
`define SAR_CONSTS_VH
// ----------------------------------------------------------------------
// result format
// ----------------------------------------------------------------------
`define SAR_RES_BITS 12
`define SAR_RES_MSB 11
// ----------------------------------------------------------------------
// sequence of one sample, counted in conversion-clock ticks
// ----------------------------------------------------------------------
`define SAR_STEPS 18
`define SAR_SAMPLE_LAST 5'h03
`define SAR_BIT_FIRST 5'h04
`define SAR_BIT_LAST 5'h0f
`define SAR_STEP_LATCH 5'h10
// ----------------------------------------------------------------------
// clocking
// ----------------------------------------------------------------------
`define SAR_REF_MHZ 20
`define SAR_CONV_MAX_MHZ 18
`define SAR_CONV_MIN_MHZ 1
// smallest divider rounds 20/18 up so the conversion clock never exceeds 18 MHz
`define SAR_DIV_MIN 5'h02
// largest divider keeps the conversion clock at 1 MHz or above
`define SAR_DIV_MAX 5'h14
// ----------------------------------------------------------------------
// power-up wait
// ----------------------------------------------------------------------
`define SAR_PUP_WAIT_NS 10000
// 10 us in reference cycles at 20 MHz
`define SAR_PUP_CYCLES 8'hc8
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SAR_RST_CODE 12'h000
`define SAR_RST_STEP 5'h00
`endif

// [logic/sar_buf2.v]
// two-entry result buffer with valid/ready on both sides
`include "sar_consts.vh"
module sar_buf2 (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [`SAR_RES_MSB:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [`SAR_RES_MSB:0] out_data
);
  reg [`SAR_RES_MSB:0] mem_r [0:1];
  reg wr_idx_r;
  reg rd_idx_r;
  reg [1:0] count_r;
  wire push;
  wire pop;

  assign in_ready = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  // data comes straight from the storage flip-flops
  assign out_data = mem_r[rd_idx_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_r[0] <= `SAR_RST_CODE;
      mem_r[1] <= `SAR_RST_CODE;
      wr_idx_r <= 1'b0;
      rd_idx_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wr_idx_r] <= in_data;
        wr_idx_r <= ~wr_idx_r;
      end
      if (pop) begin
        rd_idx_r <= ~rd_idx_r;
      end
      if (push && !pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop && !push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end
endmodule

// [bench/sar_cmp_model.sv]
// comparator model standing in for the analog front end
module sar_cmp_model (
  // trial code and held input level
  input wire [11:0] dac_code,
  input wire [11:0] vin,
  // decision
  output wire comp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ideal comparator, no offset: results must match vin exactly
  assign comp_in = (vin >= dac_code);
endmodule

// [bench/sar_conv_ctrl_chk.sv]
// port assertions of the sar conversion control
`include "sar_consts.vh"
module sar_conv_ctrl_chk (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // inputs
  input wire start_strobe,
  input wire [4:0] conv_div,
  input wire power_on,
  input wire status_clear,
  input wire result_ready,
  // outputs
  input wire [`SAR_RES_MSB:0] dac_code,
  input wire sample_hold,
  input wire result_valid,
  input wire [`SAR_RES_MSB:0] result_data,
  input wire conv_done,
  input wire done_status,
  input wire conv_ready,
  input wire conv_busy,
  input wire trigger_missed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  AST_DONE_LEVEL: assert property (conv_done && !result_ready |=> conv_done)
    else $error("done dropped before read");
  AST_HOLD_DATA: assert property (result_valid && !result_ready
    |=> result_valid && $stable(result_data))
    else $error("unread result lost");
  AST_START_READY: assert property ($rose(conv_busy) |-> conv_ready)
    else $error("start before wait over");
  AST_FIRST_TRIAL: assert property ($fell(sample_hold) && $past(power_on)
    |-> dac_code == 12'h800)
    else $error("first trial not top bit");
  AST_SAMPLE_CODE: assert property (sample_hold |-> dac_code == 12'h000)
    else $error("code set while sampling");
  AST_SAMPLE_LEN: assert property ($rose(sample_hold) && conv_div == 5'h02
    |-> sample_hold [*8] ##1 !sample_hold)
    else $error("sampling length wrong");
  AST_LATENCY: assert property ($rose(sample_hold) && conv_div == 5'h02 && !result_valid
    |-> ##[30:42] (result_valid || !conv_ready))
    else $error("result late");
  AST_MISSED: assert property (start_strobe && !conv_ready && power_on && !status_clear
    |=> trigger_missed)
    else $error("refused start not flagged");
  AST_DONE_STATUS: assert property ($rose(result_valid) |-> done_status)
    else $error("status not set on result");
  cover property (result_valid && result_ready);
  cover property ($rose(trigger_missed));
  cover property ($fell(conv_ready));
endmodule

bind sar_conv_ctrl sar_conv_ctrl_chk chk_u (.ref_clk(ref_clk), .arst_n(arst_n),
  .start_strobe(start_strobe), .conv_div(conv_div), .power_on(power_on),
  .status_clear(status_clear), .result_ready(result_ready), .dac_code(dac_code),
  .sample_hold(sample_hold), .result_valid(result_valid), .result_data(result_data),
  .conv_done(conv_done), .done_status(done_status), .conv_ready(conv_ready),
  .conv_busy(conv_busy), .trigger_missed(trigger_missed));

// [bench/sar_conv_ctrl_tb_top.sv]
// self-checking bench of the sar conversion control
module sar_conv_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic start_strobe = 1'b0;
  logic single_conversion_select = 1'b1;
  logic [4:0] conv_div = 5'h02;
  logic power_on = 1'b1;
  logic status_clear = 1'b0;
  logic frame_start = 1'b0;
  logic result_ready = 1'b0;
  logic [11:0] vin = 12'h000;
  wire comp_in, sample_hold, result_valid, conv_done, done_status, conv_ready, conv_busy;
  wire trigger_missed;
  wire [11:0] dac_code, result_data;
  int bad_count = 0;
  int checks = 0;
  int n;
  sar_conv_ctrl dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .start_strobe(start_strobe),
    .single_conversion_select(single_conversion_select), .conv_div(conv_div),
    .power_on(power_on), .status_clear(status_clear), .frame_start(frame_start),
    .comp_in(comp_in), .dac_code(dac_code), .sample_hold(sample_hold),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data),
    .conv_done(conv_done), .done_status(done_status), .conv_ready(conv_ready),
    .conv_busy(conv_busy), .trigger_missed(trigger_missed));
  sar_cmp_model cmp_u (.dac_code(dac_code), .vin(vin), .comp_in(comp_in));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // sel 0: result valid, 1: ready, 2: idle; a hang ends the run
  task automatic await(int sel, int lim);
    n = 0;
    while ((sel == 0 && result_valid !== 1'b1) || (sel == 1 && conv_ready !== 1'b1)
        || (sel == 2 && conv_busy !== 1'b0)) begin
      @(posedge ref_clk);
      n++;
      if (n > lim) begin
        bad_count++;
        $display("[FAIL] wait %0d expected end seen timeout", sel);
        results();
      end
    end
  endtask
  // frame_start held two cycles so the synchroniser surely sees the edge
  task automatic trig(bit by_frame);
    if (by_frame) frame_start <= 1'b1;
    else start_strobe <= 1'b1;
    @(posedge ref_clk);
    start_strobe <= 1'b0;
    @(posedge ref_clk);
    frame_start <= 1'b0;
  endtask
  task automatic clr();
    status_clear <= 1'b1;
    @(posedge ref_clk);
    status_clear <= 1'b0;
    @(posedge ref_clk);
    chk("missed cleared", 12'h000, 12'(trigger_missed));
  endtask
  task automatic read_word(logic [11:0] exp);
    await(0, 60);
    chk("result_data", exp, result_data);
    result_ready <= 1'b1;
    @(posedge ref_clk);
    result_ready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic t_pwrup();
    trig(1'b0);
    chk("early start flagged", 12'h001, 12'(trigger_missed));
    chk("early start idle", 12'h000, 12'(conv_busy));
    await(1, 220);
    chk("wait not short", 12'h001, 12'(n >= 190));
    clr();
    $display("test pwrup done");
  endtask
  task automatic t_single(logic [11:0] v, bit by_frame);
    vin <= v;
    trig(by_frame);
    repeat (4) @(posedge ref_clk);
    chk("trigger accepted", 12'h001, 12'(conv_busy));
    trig(1'b0);
    await(0, 60);
    chk("busy trigger flagged", 12'h001, 12'(trigger_missed));
    chk("done_status", 12'h001, 12'(done_status));
    chk("conv_done", 12'h001, 12'(conv_done));
    read_word(v);
    chk("done after read", 12'h000, 12'(conv_done));
    chk("status after read", 12'h000, 12'(done_status));
    repeat (45) @(posedge ref_clk);
    chk("one per trigger", 12'h000, 12'(result_valid));
    clr();
    $display("test single %h done", v);
  endtask
  task automatic t_div();
    conv_div <= 5'h03;
    vin <= 12'h1e1;
    repeat (6) @(posedge ref_clk);
    trig(1'b0);
    await(0, 80);
    chk("div 3 latency", 12'h001, 12'(n >= 53 && n <= 55));
    clr();
    chk("status cleared", 12'h000, 12'(done_status));
    chk("done held unread", 12'h001, 12'(conv_done));
    read_word(12'h1e1);
    conv_div <= 5'h02;
    @(posedge ref_clk);
    $display("test divider done");
  endtask
  task automatic t_cont();
    int k;
    k = 0;
    vin <= 12'h3c7;
    single_conversion_select <= 1'b0;
    trig(1'b0);
    repeat (150) @(posedge ref_clk);
    trig(1'b0);
    chk("running trigger flagged", 12'h001, 12'(trigger_missed));
    chk("stalled result held", 12'h001, 12'(result_valid));
    single_conversion_select <= 1'b1;
    result_ready <= 1'b1;
    repeat (150) begin
      @(posedge ref_clk);
      if (result_valid === 1'b1) begin
        k++;
        chk("stream word", 12'h3c7, result_data);
      end
    end
    result_ready <= 1'b0;
    chk("no word lost", 12'h001, 12'(k >= 3));
    await(2, 10);
    clr();
    $display("test continuous done");
  endtask
  task automatic t_abort();
    vin <= 12'h5a5;
    trig(1'b0);
    repeat (20) @(posedge ref_clk);
    power_on <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("sleep aborts", 12'h000, 12'(conv_busy));
    chk("sleep not ready", 12'h000, 12'(conv_ready));
    chk("no aborted word", 12'h000, 12'(result_valid));
    power_on <= 1'b1;
    @(posedge ref_clk);
    $display("test abort done");
    t_pwrup();
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    chk("dac in reset", 12'h000, dac_code);
    arst_n <= 1'b1;
    t_pwrup();
    t_single(12'ha5c, 1'b0);
    t_single(12'hfff, 1'b1);
    t_single(12'h000, 1'b0);
    t_single(12'h800, 1'b1);
    t_div();
    t_cont();
    t_abort();
    t_single(12'h7ff, 1'b0);
    results();
  end
endmodule
